// >>> rtl/jtprg_map.svh
// Constant map of the JTAG programming data registers: codes, fields, counts
`ifndef JTPRG_MAP_SVH
`define JTPRG_MAP_SVH

// Instruction register codes
`define JTPRG_IR_RESET      4'hC
`define JTPRG_IR_UNLOCK     4'h4
`define JTPRG_IR_COMMAND    4'h5
`define JTPRG_IR_PAGE_LOAD  4'h6
`define JTPRG_IR_PAGE_READ  4'h7

// Unlock signature, 0b1010_0011_0111_0000
`define JTPRG_UNLOCK_SIG    16'hA370
`define JTPRG_UNLOCK_RST    16'h0000

// Command word layout: command field on top, data field below
`define JTPRG_CMD_RST       15'h0000
`define JTPRG_CMD_MSB       14
`define JTPRG_FLD_LSB       7
`define JTPRG_BYTE_MSB      7
`define JTPRG_DONE_BIT      9

// Command field codes
`define JTPRG_C_ENTER       7'h23
`define JTPRG_C_ADDR_EXT    7'h0B
`define JTPRG_C_ADDR_HI     7'h07
`define JTPRG_C_ADDR_LO     7'h03
`define JTPRG_C_DATA_LO     7'h13
`define JTPRG_C_DATA_HI     7'h17
`define JTPRG_C_LATCH       7'h77
`define JTPRG_C_WR_PAGE     7'h35
`define JTPRG_C_WR_LOW      7'h31
`define JTPRG_C_RD_LO       7'h32
`define JTPRG_C_RD_HI       7'h36

// Mode bytes given with the enter command
`define JTPRG_M_ERASE       8'h80
`define JTPRG_M_FL_WRITE    8'h10
`define JTPRG_M_FL_READ     8'h02
`define JTPRG_M_EE_WRITE    8'h11
`define JTPRG_M_EE_READ     8'h03
`define JTPRG_M_NONE        8'h00

// Misc reset values and steps
`define JTPRG_PC_RST        24'h000000
`define JTPRG_PC_STEP       24'h000001
`define JTPRG_CNT_ZERO      16'h0000
`define JTPRG_CNT_STEP      16'h0001
`define JTPRG_BYTE_ZERO     8'h00
`define JTPRG_BE_LO         2'h1
`define JTPRG_BE_HI         2'h2
`define JTPRG_BE_BOTH       2'h3

`endif

// >>> rtl/jtprg_pkg.sv
// Types shared by the JTAG programming data register block
package jtprg_pkg;

  // Memory operation started by a write strobe command
  typedef enum logic [1:0] {
    JTPRG_OP_NONE,
    JTPRG_OP_ERASE,
    JTPRG_OP_FLASH_PAGE,
    JTPRG_OP_EE_PAGE
  } jtprg_op_t;

  // State of the test clock side
  typedef struct packed {
    logic [14:0] sr;          // Command shift path, low byte doubles as byte path
    logic [15:0] unlock;      // Unlock key shift register
    logic        unlock_ok;   // Key matched at last update
    logic        rst_bit;     // Reset chain bit
    logic        byp;         // Bypass bit for other instructions
    logic [14:0] cmd_word;    // Command applied at last update
    logic        cmd_tgl;     // Execute event toggle
    logic [7:0]  load_byte;   // Temporary byte for page load
    logic        load_tgl;    // Page load event toggle
    logic        cap_tgl;     // Page read capture event toggle
    logic        run_prev;    // Run-Test/Idle seen last cycle
    logic        tdo;         // Serial out
    logic        done_m;      // Done synchroniser, first stage
    logic        done_s;      // Done synchroniser, second stage
    logic        is_pl;       // Page load instruction active
    logic        is_pr;       // Page read instruction active
  } jtprg_link_t;

  // State of the chip clock side
  typedef struct packed {
    logic        part_reset_n;
    logic        prog_mode;
    logic [15:0] rst_cnt;
    logic [2:0]  tgl_prev;
    logic        pl_prev;
    logic        pr_prev;
    logic [7:0]  mode;
    logic [23:0] pc;
    logic [7:0]  dlo;
    logic [7:0]  dhi;
    logic        pl_first;
    logic        pl_hi;
    logic        rd_hi;
    logic [7:0]  rd_byte;
    logic [7:0]  res_byte;
    logic        done;
    logic        op_pend;
    logic        nvm_start;
    jtprg_op_t   nvm_op;
    logic        buf_we;
    logic [1:0]  buf_be;
    logic [15:0] buf_wdata;
  } jtprg_ref_t;

endpackage

// >>> rtl/jtprg_sync.sv
// Two flip-flop level synchroniser into the chip clock domain
module jtprg_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Levels in and out
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);
  // Both stages; the first is read only by the second
  typedef struct packed {
    logic [W-1:0] m;
    logic [W-1:0] s;
  } jtprg_sync_t;

  jtprg_sync_t r;
  jtprg_sync_t next_r;

  // Shift the level through both stages
  always_comb
  begin
    next_r   = r;
    next_r.m = d;
    next_r.s = r.m;
  end

  // Register the stages
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      r <= '0;
    else
      r <= next_r;
  end

  assign q = r.s;
endmodule

// >>> rtl/jtprg_link.sv
// Test clock side: reset chain, unlock key, command and flash byte paths
`include "jtprg_map.svh"
module jtprg_link (
  // Test clock and reset
  input  wire logic        tck,
  input  wire logic        nrst,
  // From the TAP controller
  input  wire logic        tdi,
  input  wire logic [3:0]  instr,
  input  wire logic        capture_dr,
  input  wire logic        shift_dr,
  input  wire logic        update_dr,
  input  wire logic        run_idle,
  // Quasi-static data from the chip side
  input  wire logic [7:0]  rd_byte,
  input  wire logic [7:0]  res_byte,
  input  wire logic        done_in,
  // Outputs
  output logic             tdo,
  output jtprg_pkg::jtprg_link_t st
);
  import jtprg_pkg::*;

  jtprg_link_t r;
  jtprg_link_t next_r;

  // Capture, shift and update of every data register
  always_comb
  begin
    next_r        = r;
    next_r.done_m = done_in;
    next_r.done_s = r.done_m;
    next_r.is_pl  = (instr == `JTPRG_IR_PAGE_LOAD);
    next_r.is_pr  = (instr == `JTPRG_IR_PAGE_READ);
    next_r.run_prev = run_idle;
    // One internal cycle per pass through Run-Test/Idle
    if (run_idle && !r.run_prev && instr == `JTPRG_IR_COMMAND)
      next_r.cmd_tgl = ~r.cmd_tgl;
    if (capture_dr)
    begin
      case (instr)
        `JTPRG_IR_COMMAND:
          begin
            // Result of the previous command, done flag at its fixed bit
            next_r.sr = `JTPRG_CMD_RST;
            next_r.sr[`JTPRG_BYTE_MSB:0] = res_byte;
            next_r.sr[`JTPRG_DONE_BIT]   = r.done_s;
          end
        `JTPRG_IR_PAGE_READ:
          begin
            next_r.sr[`JTPRG_BYTE_MSB:0] = rd_byte;
            next_r.cap_tgl = ~r.cap_tgl;
          end
        default:
          next_r.byp = 1'b0;
      endcase
    end
    else if (shift_dr)
    begin
      // Least significant bit leaves first, new bit enters at the top
      case (instr)
        `JTPRG_IR_RESET:
          next_r.rst_bit = tdi;
        `JTPRG_IR_UNLOCK:
          next_r.unlock = {tdi, r.unlock[15:1]};
        `JTPRG_IR_COMMAND:
          next_r.sr = {tdi, r.sr[`JTPRG_CMD_MSB:1]};
        `JTPRG_IR_PAGE_LOAD, `JTPRG_IR_PAGE_READ:
          next_r.sr[`JTPRG_BYTE_MSB:0] = {tdi, r.sr[`JTPRG_BYTE_MSB:1]};
        default:
          next_r.byp = tdi;
      endcase
    end
    else if (update_dr)
    begin
      case (instr)
        `JTPRG_IR_UNLOCK:
          next_r.unlock_ok = (r.unlock == `JTPRG_UNLOCK_SIG);
        `JTPRG_IR_COMMAND:
          next_r.cmd_word = r.sr;
        `JTPRG_IR_PAGE_LOAD:
          begin
            // Temporary copy so the next shift cannot disturb the write
            next_r.load_byte = r.sr[`JTPRG_BYTE_MSB:0];
            next_r.load_tgl  = ~r.load_tgl;
          end
        default:
          next_r.byp = r.byp;
      endcase
    end
    // Serial out shows the bit that will leave next
    case (instr)
      `JTPRG_IR_RESET:   next_r.tdo = next_r.rst_bit;
      `JTPRG_IR_UNLOCK:  next_r.tdo = next_r.unlock[0];
      `JTPRG_IR_COMMAND, `JTPRG_IR_PAGE_LOAD, `JTPRG_IR_PAGE_READ:
        next_r.tdo = next_r.sr[0];
      default:           next_r.tdo = next_r.byp;
    endcase
  end

  // Register the test clock state; key clears at power-on
  always_ff @(posedge tck or negedge nrst)
  begin
    if (!nrst)
    begin
      r        <= '0;
      r.unlock <= `JTPRG_UNLOCK_RST;
    end
    else
      r <= next_r;
  end

  assign tdo = r.tdo;
  assign st  = r;
endmodule

// >>> rtl/jtprg_top.sv
// JTAG programming data registers with the chip-side command engine
//
// Behaviour
// - Instruction 0x6 selects command low byte path
// - Page-load update copies byte, writes buffer promptly
// - Page-load alternates low/high, low first
// - Page-load pre-increments counter before each low byte except first
// - Instruction 0x7 captures flash byte, low first
// - Page-read post-increments counter after high byte
// - Byte register shifts one bit per clock
// - Reset bit holds part in reset immediately
// - Reset persists for fuse-selected time-out after release
// - Unlock only while key equals signature
// - Key clears at power-on, cleared on exit
// - 15-bit command in, previous result out
// - Flash read returns low then high byte
// - All shift paths least significant bit first
// - Each Run-Test/Idle pass under instruction 0x5 executes one command while unlocked
`include "jtprg_map.svh"
module jtprg_top #(
  // Reset time-out counts in chip clock cycles, picked by the fuse
  parameter logic [15:0] TOUT_SHORT = 16'h0040,
  parameter logic [15:0] TOUT_LONG  = 16'h1000
) (
  // Chip clock and power-on reset
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  // Test clock side from the TAP controller
  input  wire logic                 tck,
  input  wire logic                 tdi,
  input  wire logic [3:0]           tap_instr,
  input  wire logic                 tap_capture_dr,
  input  wire logic                 tap_shift_dr,
  input  wire logic                 tap_update_dr,
  input  wire logic                 tap_run_idle,
  output logic                      tdo,

  // Clock option fuse
  input  wire logic                 fuse_long_tout,

  // Part reset and programming status
  output logic                      part_reset_n,
  output logic                      prog_mode,

  // Memory controller
  input  wire logic                 nvm_busy,
  input  wire logic [15:0]          nvm_rdata,
  output logic [23:0]               nvm_addr,
  output logic                      nvm_start,
  output jtprg_pkg::jtprg_op_t      nvm_op,

  // Page buffer write port
  output logic                      buf_we,
  output logic [1:0]                buf_be,
  output logic [15:0]               buf_wdata
);
  import jtprg_pkg::*;

  // Test clock side state as seen from here
  jtprg_link_t lk;

  // Chip side state and its next value
  jtprg_ref_t  r;
  jtprg_ref_t  next_r;

  // Synchronised levels from the test clock side
  logic [6:0]  sync_in;
  logic [6:0]  sync_out;
  logic        s_rst;
  logic        s_unlock;
  logic        s_pl;
  logic        s_pr;
  logic [2:0]  s_tgl;

  // Test clock domain logic
  jtprg_link u_link (
    .tck        (tck),
    .nrst       (nrst),
    .tdi        (tdi),
    .instr      (tap_instr),
    .capture_dr (tap_capture_dr),
    .shift_dr   (tap_shift_dr),
    .update_dr  (tap_update_dr),
    .run_idle   (tap_run_idle),
    .rd_byte    (r.rd_byte),
    .res_byte   (r.res_byte),
    .done_in    (r.done),
    .tdo        (tdo),
    .st         (lk)
  );

  // Levels and event toggles cross on two flip-flops each
  // Words they guard are read as held levels
  assign sync_in = {lk.rst_bit, lk.unlock_ok, lk.is_pl, lk.is_pr,
                    lk.cmd_tgl, lk.load_tgl, lk.cap_tgl};

  jtprg_sync #(.W(7)) u_sync (
    .clk  (ref_clk),
    .nrst (nrst),
    .d    (sync_in),
    .q    (sync_out)
  );

  assign s_rst    = sync_out[6];
  assign s_unlock = sync_out[5];
  assign s_pl     = sync_out[4];
  assign s_pr     = sync_out[3];
  assign s_tgl    = sync_out[2:0];

  // Chip side: reset stretch, command engine, page load and page read
  always_comb
  begin
    logic        ev_cmd;
    logic        ev_load;
    logic        ev_cap;
    logic [6:0]  cfield;
    logic [7:0]  dfield;
    logic [23:0] pc_now;
    ev_cmd  = 1'b0;
    ev_load = 1'b0;
    ev_cap  = 1'b0;
    cfield  = 7'h00;
    dfield  = `JTPRG_BYTE_ZERO;
    pc_now  = r.pc;
    next_r  = r;

    // Strobes last one cycle
    next_r.nvm_start = 1'b0;
    next_r.buf_we    = 1'b0;

    // A toggle change is one event; the word it guards is already stable
    next_r.tgl_prev = s_tgl;
    ev_cmd  = s_tgl[2] ^ r.tgl_prev[2];
    ev_load = s_tgl[1] ^ r.tgl_prev[1];
    ev_cap  = s_tgl[0] ^ r.tgl_prev[0];

    // Reset is held while the chain bit is one, then for the time-out
    // Reload while held: any pulse gets the full time-out
    if (s_rst)
    begin
      next_r.part_reset_n = 1'b0;
      next_r.rst_cnt = fuse_long_tout ? TOUT_LONG : TOUT_SHORT;
    end
    else if (r.rst_cnt != `JTPRG_CNT_ZERO)
    begin
      next_r.part_reset_n = 1'b0;
      next_r.rst_cnt = r.rst_cnt - `JTPRG_CNT_STEP;
    end
    else
      next_r.part_reset_n = 1'b1;

    // Programming follows the key match; a cleared key leaves the mode
    next_r.prog_mode = s_unlock;
    if (!s_unlock)
      next_r.mode = `JTPRG_M_NONE;

    // Completion: low from a start until the memory has been busy and idle
    if (r.op_pend && nvm_busy)
      next_r.op_pend = 1'b0;
    next_r.done = !nvm_busy && !r.op_pend && !r.nvm_start;
    // A strobe below overrides both; the set wins

    // Split the applied command into its two fields
    cfield = lk.cmd_word[`JTPRG_CMD_MSB:`JTPRG_FLD_LSB + 1];
    dfield = lk.cmd_word[`JTPRG_BYTE_MSB:0];

    // One executed command per Run-Test/Idle pass
    if (ev_cmd && s_unlock)
    begin
      case (cfield)
        // Mode byte decides which strobes act
        `JTPRG_C_ENTER:
          next_r.mode = dfield;
        `JTPRG_C_ADDR_EXT:
          next_r.pc[23:16] = dfield;
        `JTPRG_C_ADDR_HI:
          next_r.pc[15:8] = dfield;
        `JTPRG_C_ADDR_LO:
          next_r.pc[7:0] = dfield;
        `JTPRG_C_DATA_LO:
          next_r.dlo = dfield;
        `JTPRG_C_DATA_HI:
          next_r.dhi = dfield;
        `JTPRG_C_LATCH:
          begin
            // Top bit high latches the loaded word into the buffer
            next_r.buf_we    = 1'b1;
            next_r.buf_be    = (r.mode == `JTPRG_M_EE_WRITE) ?
                               `JTPRG_BE_LO : `JTPRG_BE_BOTH;
            next_r.buf_wdata = {r.dhi, r.dlo};
          end
        `JTPRG_C_WR_PAGE:
          begin
            if (r.mode == `JTPRG_M_FL_WRITE)
            begin
              next_r.nvm_start = 1'b1;
              next_r.nvm_op    = JTPRG_OP_FLASH_PAGE;
              next_r.op_pend   = 1'b1;
              next_r.done      = 1'b0;
            end
          end
        `JTPRG_C_WR_LOW:
          begin
            // Same strobe field starts erase or EEPROM page write
            if (r.mode == `JTPRG_M_ERASE || r.mode == `JTPRG_M_EE_WRITE)
            begin
              next_r.nvm_start = 1'b1;
              next_r.nvm_op    = (r.mode == `JTPRG_M_ERASE) ?
                                 JTPRG_OP_ERASE : JTPRG_OP_EE_PAGE;
              next_r.op_pend   = 1'b1;
              next_r.done      = 1'b0;
            end
          end
        // Result returns at the next capture
        `JTPRG_C_RD_LO:
          next_r.res_byte = nvm_rdata[7:0];
        `JTPRG_C_RD_HI:
          next_r.res_byte = nvm_rdata[15:8];
        default:
          // Idle and poll words keep the result as it was; the strobe
          // needs no leading word when the field is already set
          next_r.res_byte = r.res_byte;
      endcase
    end

    // Page load: fresh entry restarts on the low byte at the preset address
    next_r.pl_prev = s_pl;
    // Entry beats a same-cycle update
    if (s_pl && !r.pl_prev)
    begin
      next_r.pl_first = 1'b1;
      next_r.pl_hi    = 1'b0;
    end
    else if (ev_load && s_pl && s_unlock)
    begin
      // Pre-increment before each low byte except the very first
      if (!r.pl_hi && !r.pl_first)
        pc_now = r.pc + `JTPRG_PC_STEP;
      next_r.pc        = pc_now;
      next_r.pl_first  = 1'b0;
      next_r.pl_hi     = ~r.pl_hi;
      next_r.buf_we    = 1'b1;
      next_r.buf_be    = r.pl_hi ? `JTPRG_BE_HI : `JTPRG_BE_LO;
      next_r.buf_wdata = {lk.load_byte, lk.load_byte};
    end

    // Page read: fresh entry presents the low byte of the preset address
    next_r.pr_prev = s_pr;
    // Entry beats a same-cycle capture
    if (s_pr && !r.pr_prev)
      next_r.rd_hi = 1'b0;
    else if (ev_cap && s_pr && s_unlock)
    begin
      // Post-increment after every high byte, the first included
      if (r.rd_hi)
        next_r.pc = r.pc + `JTPRG_PC_STEP;
      next_r.rd_hi = ~r.rd_hi;
    end

    // Keep the next byte to capture ready; it settles well before the
    // next capture since a byte shift takes eight test clocks
    next_r.rd_byte = r.rd_hi ? nvm_rdata[15:8] : nvm_rdata[7:0];
  end

  // Register the chip side state
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r              <= '0;
      // Part runs, flag reads done
      r.part_reset_n <= 1'b1;
      r.rst_cnt      <= `JTPRG_CNT_ZERO;
      r.pc           <= `JTPRG_PC_RST;
      r.mode         <= `JTPRG_M_NONE;
      r.done         <= 1'b1;
      r.nvm_op       <= JTPRG_OP_NONE;
    end
    else
      r <= next_r;
  end

  // Outputs straight from flip-flops
  assign part_reset_n = r.part_reset_n;
  assign prog_mode    = r.prog_mode;
  assign nvm_addr     = r.pc;
  assign nvm_start    = r.nvm_start;
  assign nvm_op       = r.nvm_op;
  assign buf_we       = r.buf_we;
  assign buf_be       = r.buf_be;
  assign buf_wdata    = r.buf_wdata;
endmodule

// >>> bench/jtprg_checker.sv
// Port assertions for the JTAG programming block, bound to its top module
module jtprg_checker #(
  parameter logic [15:0] TOUT_SHORT = 16'h0040,
  parameter logic [15:0] TOUT_LONG  = 16'h1000
) (
  // Clocks and reset
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       tck,
  // Test access side
  input wire logic       tdi,
  input wire logic [3:0] tap_instr,
  input wire logic       tap_capture_dr,
  input wire logic       tap_shift_dr,
  input wire logic       tap_update_dr,
  input wire logic       tdo,
  // Chip side
  input wire logic       fuse_long_tout,
  input wire logic       part_reset_n,
  input wire logic       prog_mode,
  input wire logic       nvm_start,
  input wire logic       buf_we,
  input wire logic [1:0] buf_be
);
  timeunit 1ns;
  timeprecision 1ps;

  // Cycles spent in reset so far
  logic [15:0] low_cnt;

  // Restarts on a chain shift, so only the time-out counts
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      low_cnt <= 16'h0000;
    else if (part_reset_n || (tap_shift_dr && tap_instr == 4'hC))
      low_cnt <= 16'h0000;
    else
      low_cnt <= low_cnt + 16'h0001;
  end

  // Page-load update, and the buffer write due within 11 tck (35 ref cycles)
  sequence load_upd_s;
    $rose(tap_update_dr) && tap_instr == 4'h6 && prog_mode;
  endsequence
  sequence fill_soon_s;
    ##[1:35] buf_we;
  endsequence

  start_pulse_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    nvm_start |=> !nvm_start) else $error("start strobe wider than one cycle");
  fill_pulse_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    buf_we |=> !buf_we) else $error("buffer write wider than one cycle");
  fill_lane_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    buf_we |-> buf_be != 2'h0) else $error("buffer write without byte lane");
  start_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    nvm_start |-> prog_mode) else $error("memory start while locked");
  fill_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    buf_we |-> prog_mode) else $error("buffer write while locked");
  key_source_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(prog_mode) |-> tap_instr == 4'h4) else $error("unlock outside key path");
  fill_time_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    load_upd_s |-> fill_soon_s) else $error("page load byte written late");
  rst_time_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(part_reset_n) |-> low_cnt >= (fuse_long_tout ? TOUT_LONG : TOUT_SHORT))
    else $error("part left reset before time-out");
  rst_echo_a: assert property (@(posedge tck) disable iff (!nrst)
    tap_instr == 4'hC && tap_shift_dr && !tap_capture_dr |=> tdo == $past(tdi))
    else $error("reset chain bit not shown on serial out");
  rst_hold_a: assert property (@(posedge tck) disable iff (!nrst)
    tap_instr == 4'hC && tap_shift_dr && !tap_capture_dr && tdi |-> ##[1:2] !part_reset_n)
    else $error("reset chain one did not reset the part");
endmodule

// >>> bench/jtprg_prog.sv
// Programmer model: test clock runs only inside frames, drives TAP levels
module jtprg_prog (
  // Test clock and TAP state levels
  output logic       tck,
  output logic       tdi,
  output logic [3:0] ir,
  output logic       cap,
  output logic       sh,
  output logic       up,
  output logic       ri,
  // Serial data back from the device
  input  wire logic  tdo
);
  timeunit 1ns;
  timeprecision 1ps;

  // Clock parked low and all levels idle until the first frame
  initial
  begin
    {tck, tdi, ir, cap, sh, up, ri} = 10'h000;
  end

  // One 80 ns test clock period; levels change only after the falling edge
  task automatic tick();
    #40;
    tck = 1'b1;
    #40;
    tck = 1'b0;
  endtask

  // Full data scan: capture, n shifts, update, optional execute pass
  task automatic frame(input logic [3:0] code, input int n, input logic [15:0] din,
                       input logic run, output logic [15:0] dout);
    dout = 16'h0000;
    ir = code;
    tick();
    cap = 1'b1;
    tick();
    cap = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      dout[i] = tdo;
      tdi = din[i];
      sh = 1'b1;
      tick();
    end
    sh = 1'b0;
    // Released data line shows the inverse, never the last bit
    tdi = ~tdi;
    up = 1'b1;
    tick();
    up = 1'b0;
    ri = run;
    tick();
    ri = 1'b0;
    tick();
    #400;
  endtask
endmodule

// >>> bench/jtprg_top_test.sv
// Self-checking bench: programmer model, memory model and expected results
`include "jtprg_map.svh"
module jtprg_top_test
  import jtprg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Clock, reset and device pins
  logic        ref_clk        = 1'b0;
  logic        nrst           = 1'b1;
  logic        fuse_long_tout = 1'b1;
  logic        nvm_busy       = 1'b0;
  logic [15:0] nvm_rdata      = 16'h0000;
  logic        tck;
  logic        tdi;
  logic [3:0]  tap_instr;
  logic        tap_capture_dr;
  logic        tap_shift_dr;
  logic        tap_update_dr;
  logic        tap_run_idle;
  logic        tdo;
  logic        part_reset_n;
  logic        prog_mode;
  logic [23:0] nvm_addr;
  logic        nvm_start;
  jtprg_op_t   nvm_op;
  logic        buf_we;
  logic [1:0]  buf_be;
  logic [15:0] buf_wdata;
  // Bench model state: started operations and buffer writes seen
  int          num_errors = 0;
  int          cmp_count  = 0;
  int          bcnt       = 0;
  jtprg_op_t   ops[$];
  logic [41:0] wq[$];
  logic [15:0] r;

  always #12.5 ref_clk = ~ref_clk;

  jtprg_top #(.TOUT_SHORT(16'h0004), .TOUT_LONG(16'h0028)) DUT (
    .ref_clk, .nrst, .tck, .tdi, .tap_instr, .tap_capture_dr, .tap_shift_dr,
    .tap_update_dr, .tap_run_idle, .tdo, .fuse_long_tout, .part_reset_n,
    .prog_mode, .nvm_busy, .nvm_rdata, .nvm_addr, .nvm_start, .nvm_op,
    .buf_we, .buf_be, .buf_wdata
  );

  jtprg_prog P (
    .tck(tck), .tdi(tdi), .ir(tap_instr), .cap(tap_capture_dr), .sh(tap_shift_dr),
    .up(tap_update_dr), .ri(tap_run_idle), .tdo(tdo)
  );

  // Memory contents as a fixed function of the word address
  function automatic logic [15:0] mem_word(input logic [23:0] a);
    return {a[7:0] ^ 8'hA5, a[15:8] ^ a[7:0] ^ 8'h3C};
  endfunction

  // Memory controller: busy for about 20 cycles after each start
  always @(posedge ref_clk)
  begin
    nvm_rdata <= mem_word(nvm_addr);
    nvm_busy <= (bcnt > 2);
    bcnt <= nvm_start ? 22 : (bcnt > 0 ? bcnt - 1 : 0);
    if (nvm_start)
      ops.push_back(nvm_op);
    if (buf_we)
      wq.push_back({nvm_addr, buf_be, buf_wdata});
  end

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Checks land on the falling chip clock edge, clear of register updates
  task automatic fr(input logic [3:0] ir, input int n, input logic [15:0] d, input logic run);
    P.frame(ir, n, d, run, r);
    @(negedge ref_clk);
  endtask

  task automatic cmd(input logic [6:0] f, input logic [7:0] d);
    fr(4'h5, 15, {1'b0, f, d}, 1'b1);
  endtask

  // Bounded completion poll; the done flag must come up
  task automatic poll(input logic [6:0] f, input logic [7:0] d);
    int n = 0;
    cmd(f, d);
    while (r[9] !== 1'b1 && n < 40)
    begin
      cmd(f, d);
      n++;
    end
    chk(r[9], 1'b1);
  endtask

  task automatic latch();
    cmd(7'h37, 8'h00);
    cmd(7'h77, 8'h00);
    cmd(7'h37, 8'h00);
  endtask

  task automatic take_w(input logic [23:0] a, input logic [1:0] be, input logic [15:0] d);
    chk(wq.pop_front(), {a, be, d});
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    logic [23:0] a;
    logic [7:0]  b[4];
    logic [15:0] m;
    logic [41:0] w;
    a = 24'($urandom(32'h565d1ca9)) & 24'h7FFEFE;
    nrst <= 1'b0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    @(negedge ref_clk);
    chk({part_reset_n, prog_mode, nvm_addr}, {2'b10, 24'h000000});
    // Reset chain: immediate hold, then the long time-out after release
    fr(4'hC, 1, 16'h0001, 1'b0);
    chk(part_reset_n, 1'b0);
    fr(4'hC, 1, 16'h0000, 1'b0);
    chk(part_reset_n, 1'b0);
    repeat (50) @(negedge ref_clk);
    chk(part_reset_n, 1'b1);
    fr(4'hC, 1, 16'h0001, 1'b0);
    // A key with its top bit wrong must not unlock
    fr(4'h4, 16, `JTPRG_UNLOCK_SIG ^ 16'h8000, 1'b0);
    chk(prog_mode, 1'b0);
    fr(4'h4, 16, `JTPRG_UNLOCK_SIG, 1'b0);
    chk(prog_mode, 1'b1);
    cmd(7'h23, 8'h10);
    cmd(7'h0B, a[23:16]);
    cmd(7'h07, a[15:8]);
    cmd(7'h03, a[7:0]);
    chk(nvm_addr, a);
    // Page load of four random bytes: low, high, then next word
    for (int i = 0; i < 4; i++)
    begin
      b[i] = 8'($urandom);
      fr(4'h6, 8, {8'h00, b[i]}, 1'b0);
    end
    for (int i = 0; i < 4; i++)
      take_w(a + 24'(i / 2), (i % 2) ? 2'h2 : 2'h1, {b[i], b[i]});
    chk(nvm_addr, a + 24'h000001);
    cmd(7'h03, a[7:0]);
    cmd(7'h13, b[0]);
    cmd(7'h17, b[1]);
    latch();
    take_w(a, 2'h3, {b[1], b[0]});
    // The write page word starts the flash write at once; the next word reads done low
    cmd(7'h35, 8'h00);
    cmd(7'h37, 8'h00);
    chk(r[9], 1'b0);
    poll(7'h37, 8'h00);
    chk(ops.pop_front(), JTPRG_OP_FLASH_PAGE);
    // Flash read through commands, result shows on the following shifts
    m = mem_word(a);
    cmd(7'h23, 8'h02);
    cmd(7'h32, 8'h00);
    cmd(7'h36, 8'h00);
    chk(r[7:0], m[7:0]);
    cmd(7'h37, 8'h00);
    chk(r[7:0], m[15:8]);
    // Page read: low, high, then the counter moves on
    for (int i = 0; i < 4; i++)
    begin
      fr(4'h7, 8, 16'h0000, 1'b0);
      m = mem_word(a + 24'(i / 2));
      chk(r[7:0], (i % 2) ? m[15:8] : m[7:0]);
    end
    chk(nvm_addr, a + 24'h000002);
    cmd(7'h23, 8'h80);
    cmd(7'h31, 8'h80);
    cmd(7'h33, 8'h80);
    chk(r[9], 1'b0);
    cmd(7'h33, 8'h80);
    poll(7'h33, 8'h80);
    chk(ops.pop_front(), JTPRG_OP_ERASE);
    cmd(7'h23, 8'h11);
    cmd(7'h07, a[15:8]);
    cmd(7'h03, a[7:0]);
    cmd(7'h13, b[2]);
    latch();
    w = wq.pop_front();
    chk({w[41:16], w[7:0]}, {a, 2'h1, b[2]});
    cmd(7'h33, 8'h00);
    cmd(7'h31, 8'h00);
    cmd(7'h33, 8'h00);
    poll(7'h33, 8'h00);
    chk(ops.pop_front(), JTPRG_OP_EE_PAGE);
    // Leave: clear the key, release reset with the short time-out
    @(posedge ref_clk);
    fuse_long_tout <= 1'b0;
    fr(4'h4, 16, 16'h0000, 1'b0);
    chk(prog_mode, 1'b0);
    fr(4'hC, 1, 16'h0000, 1'b0);
    chk(part_reset_n, 1'b1);
    end_of_test();
  end

  // Watchdog well beyond the expected run of about 90 us
  initial
  begin
    #1ms;
    num_errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule

bind jtprg_top jtprg_checker #(.TOUT_SHORT(TOUT_SHORT), .TOUT_LONG(TOUT_LONG)) u_chk (
  .ref_clk, .nrst, .tck, .tdi, .tap_instr, .tap_capture_dr, .tap_shift_dr,
  .tap_update_dr, .tdo, .fuse_long_tout, .part_reset_n, .prog_mode, .nvm_start,
  .buf_we, .buf_be
);
